// [rtl/dual_adc_parallel_output.sv]
// Top level: two conversion channels, pin controls and register slave
`timescale 1ns/10ps
module dual_adc_parallel_output
  import adc_out_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Stage decisions from the analog pipelines
  input wire logic [CODE_W-1:0] chan_a_stage_codes,
  input wire logic chan_a_over_range,
  input wire logic [CODE_W-1:0] chan_b_stage_codes,
  input wire logic chan_b_over_range,
  // Output enables, with a flag telling whether the pin is driven at all
  input wire logic chan_a_oe_n,
  input wire logic chan_a_oe_n_driven,
  input wire logic chan_b_oe_n,
  input wire logic chan_b_oe_n_driven,
  // Static configuration pins
  input wire logic span_select,
  input wire logic reference_source_select,
  input wire logic reference_source_select_driven,
  // Channel A outputs; bit 11 is chan_a_top_bit, bit 0 chan_a_bottom_bit
  output logic [WORD_W-1:0] chan_a_word,
  output logic chan_a_word_oe,
  output logic range_exceeded_flag_a,
  output logic word_valid_strobe_a,
  // Channel B outputs; bit 11 is chan_b_top_bit, bit 0 chan_b_bottom_bit
  output logic [WORD_W-1:0] chan_b_word,
  output logic chan_b_word_oe,
  output logic range_exceeded_flag_b,
  output logic word_valid_strobe_b,
  // Analog configuration
  output logic full_scale_3v,
  output logic use_external_ref,
  // Interrupt
  output logic irq
);

  adc_chan_if if_a ();
  adc_chan_if if_b ();

  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_enable_q;
  logic [WORD_W:0] cap_a_q;
  logic [WORD_W:0] cap_b_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr_d;
  logic oe_a_eff;
  logic oe_b_eff;
  logic ref_eff;
  logic [PIN_W-1:0] pin_stat;

  // Write channel holding state
  logic aw_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_full_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic [DATA_W-1:0] rd_val;
  logic rd_hit;

  adc_chan_pipe u_chan_a (
    .mclk(mclk),
    .rst(rst),
    .ch(if_a.pipe)
  );

  adc_chan_pipe u_chan_b (
    .mclk(mclk),
    .rst(rst),
    .ch(if_b.pipe)
  );

  assign if_a.stage_codes = chan_a_stage_codes;
  assign if_a.over_range_in = chan_a_over_range;
  assign if_a.run = ctrl_q[CTRL_RUN_A];
  assign if_b.stage_codes = chan_b_stage_codes;
  assign if_b.over_range_in = chan_b_over_range;
  assign if_b.run = ctrl_q[CTRL_RUN_B];

  assign chan_a_word = if_a.word;
  assign chan_b_word = if_b.word;
  assign range_exceeded_flag_a = if_a.range_flag;
  assign range_exceeded_flag_b = if_b.range_flag;
  assign word_valid_strobe_a = if_a.word_valid;
  assign word_valid_strobe_b = if_b.word_valid;

  assign oe_a_eff = chan_a_oe_n_driven ? !chan_a_oe_n : 1'b1;
  assign oe_b_eff = chan_b_oe_n_driven ? !chan_b_oe_n : 1'b1;

  assign chan_a_word_oe = oe_a_eff;
  assign chan_b_word_oe = oe_b_eff;

  assign ref_eff = reference_source_select_driven ? reference_source_select : 1'b1;

  always_ff @(posedge mclk) begin
    if (rst) begin
      full_scale_3v <= 1'b0;
      use_external_ref <= 1'b0;
    end else begin
      full_scale_3v <= span_select;
      use_external_ref <= ref_eff;
    end
  end

  // Last valid word of each channel, for software
  always_ff @(posedge mclk) begin
    if (rst) begin
      cap_a_q <= '0;
      cap_b_q <= '0;
    end else begin
      if (if_a.word_valid) begin
        cap_a_q <= {if_a.range_flag, if_a.word};
      end
      if (if_b.word_valid) begin
        cap_b_q <= {if_b.range_flag, if_b.word};
      end
    end
  end

  // Interrupt sources: out-of-range word emitted
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_RANGE_A] = if_a.word_valid && if_a.range_flag;
    irq_set[IRQ_RANGE_B] = if_b.word_valid && if_b.range_flag;
  end

  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;

  always_comb begin
    irq_clr_d = '0;
    if (wr_fire && aw_addr_q == OFF_IRQ_CLEAR && w_strb_q[0]) begin
      irq_clr_d = w_data_q[IRQ_W-1:0];
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_status_q <= IRQ_RST;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr_d) | irq_set;
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // Write address and data accepted in either order
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  // Register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      irq_enable_q <= IRQ_RST;
    end else if (wr_fire) begin
      if (aw_addr_q == OFF_CTRL) begin
        ctrl_q <= CTRL_W'(apply_strb(DATA_W'(ctrl_q), w_data_q, w_strb_q));
      end
      if (aw_addr_q == OFF_IRQ_ENABLE) begin
        irq_enable_q <= IRQ_W'(apply_strb(DATA_W'(irq_enable_q), w_data_q, w_strb_q));
      end
    end
  end

  // Write response
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr_q)
        OFF_CTRL, OFF_IRQ_CLEAR, OFF_IRQ_ENABLE: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    pin_stat = '0;
    pin_stat[PIN_SPAN_3V] = full_scale_3v;
    pin_stat[PIN_REF_EXT] = use_external_ref;
    pin_stat[PIN_OE_A] = oe_a_eff;
    pin_stat[PIN_OE_B] = oe_b_eff;
    pin_stat[PIN_VALID_A] = if_a.word_valid;
    pin_stat[PIN_VALID_B] = if_b.word_valid;
  end

  // Read decode; clear register reads as zero
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL: rd_val = DATA_W'(ctrl_q);
      OFF_PINSTAT: rd_val = DATA_W'(pin_stat);
      OFF_IRQ_STATUS: rd_val = DATA_W'(irq_status_q);
      OFF_IRQ_CLEAR: rd_val = '0;
      OFF_IRQ_ENABLE: rd_val = DATA_W'(irq_enable_q);
      OFF_WORD_A: rd_val = DATA_W'(cap_a_q);
      OFF_WORD_B: rd_val = DATA_W'(cap_b_q);
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_oe_follows_pin: assert property (@(posedge mclk) disable iff (rst)
    chan_a_oe_n_driven && chan_a_oe_n |-> !chan_a_word_oe && chan_b_word_oe == oe_b_eff)
    else $error("channel A word driven while its enable is high");

  a_oe_pull_low: assert property (@(posedge mclk) disable iff (rst)
    !chan_b_oe_n_driven |-> chan_b_word_oe)
    else $error("undriven enable on channel B did not enable outputs");

  a_span_select: assert property (@(posedge mclk) disable iff (rst)
    span_select ##1 span_select |=> full_scale_3v)
    else $error("span select high did not choose the 3V span");

  a_ref_pull_up: assert property (@(posedge mclk) disable iff (rst)
    !reference_source_select_driven |=> use_external_ref)
    else $error("open reference select did not choose external");

  a_range_irq: assert property (@(posedge mclk) disable iff (rst)
    word_valid_strobe_a && range_exceeded_flag_a && irq_enable_q[IRQ_RANGE_A] |=> irq)
    else $error("out-of-range word did not raise the interrupt");

endmodule // dual_adc_parallel_output

// [rtl/adc_out_pkg.sv]
// Shared constants, register map and helper functions for the dual converter output block
package adc_out_pkg;

  // Converter word and pipeline shape
  localparam int WORD_W = 12;
  localparam int N_STAGES = 11;
  localparam int CODE_W = 2 * N_STAGES;
  localparam int LATENCY = 6;
  localparam int TOP_BIT = WORD_W - 1;
  localparam logic [1:0] STAGE_CODE_MAX = 2'h2;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PINSTAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_WORD_A = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_WORD_B = 8'h18;

  // Control register: one run bit per channel
  localparam int CTRL_W = 2;
  localparam int CTRL_RUN_A = 0;
  localparam int CTRL_RUN_B = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h3;

  // Pin status register fields
  localparam int PIN_SPAN_3V = 0;
  localparam int PIN_REF_EXT = 1;
  localparam int PIN_OE_A = 2;
  localparam int PIN_OE_B = 3;
  localparam int PIN_VALID_A = 4;
  localparam int PIN_VALID_B = 5;
  localparam int PIN_W = 6;

  // Interrupt bits: out-of-range word emitted on a channel
  localparam int IRQ_W = 2;
  localparam int IRQ_RANGE_A = 0;
  localparam int IRQ_RANGE_B = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // Captured word register: flag sits above the word
  localparam int CAP_FLAG_BIT = WORD_W;

  // Merge the stage decisions: stage 0 weighs most, stages overlap by one bit
  function automatic logic [WORD_W-1:0] merge_stages(input logic [CODE_W-1:0] codes);
    logic [WORD_W-1:0] acc;
    logic [1:0] c;
    acc = '0;
    for (int i = 0; i < N_STAGES; i++) begin
      c = codes[2*i +: 2];
      if (i < N_STAGES - 1 && c > STAGE_CODE_MAX) begin
        c = STAGE_CODE_MAX;
      end
      acc = acc + (WORD_W'(c) << (N_STAGES - 1 - i));
    end
    return acc;
  endfunction

  // Byte-lane write merge
  function automatic logic [DATA_W-1:0] apply_strb(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [3:0] strb);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

endpackage

// [rtl/adc_chan_if.sv]
// Signals between the top level and one conversion channel
`timescale 1ns/10ps
interface adc_chan_if;
  import adc_out_pkg::*;
  logic [CODE_W-1:0] stage_codes;
  logic over_range_in;
  logic run;
  logic [WORD_W-1:0] word;
  logic range_flag;
  logic word_valid;

  modport ctrl (output stage_codes, output over_range_in, output run,
                input word, input range_flag, input word_valid);
  modport pipe (input stage_codes, input over_range_in, input run,
                output word, output range_flag, output word_valid);
endinterface

// [rtl/adc_chan_pipe.sv]
// One conversion channel: stage merge and fixed-latency output pipeline
`timescale 1ns/10ps
module adc_chan_pipe
  import adc_out_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Channel signals
  adc_chan_if.pipe ch
);

  logic [WORD_W-1:0] word_q [LATENCY+1];
  logic [LATENCY:0] flag_q;
  logic [LATENCY:0] vld_q;

  always_ff @(posedge mclk) begin
    word_q[0] <= merge_stages(ch.stage_codes);
    for (int i = 1; i <= LATENCY; i++) begin
      word_q[i] <= word_q[i-1];
    end
  end

  always_ff @(posedge mclk) begin
    flag_q <= {flag_q[LATENCY-1:0], ch.over_range_in};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      vld_q <= '0;
    end else begin
      vld_q <= {vld_q[LATENCY-1:0], ch.run};
    end
  end

  assign ch.word = word_q[LATENCY];
  assign ch.range_flag = flag_q[LATENCY];
  assign ch.word_valid = vld_q[LATENCY];

  a_word_latency: assert property (@(posedge mclk) disable iff (rst)
    ch.word_valid |-> ch.word == merge_stages($past(ch.stage_codes, 7)))
    else $error("word does not match stage codes six cycles after sampling");

  a_flag_latency: assert property (@(posedge mclk) disable iff (rst)
    ch.word_valid |-> ch.range_flag == $past(ch.over_range_in, 7))
    else $error("range flag not aligned with its word");

  a_valid_latency: assert property (@(posedge mclk) disable iff (rst)
    ch.run ##1 ch.run |-> ##6 ch.word_valid)
    else $error("valid strobe missing six cycles after a running sample");

  a_valid_needs_run: assert property (@(posedge mclk) disable iff (rst)
    ch.word_valid |-> $past(ch.run, 7))
    else $error("valid strobe without a sample taken while running");

endmodule // adc_chan_pipe

// [sim/capture_model.sv]
// Far-side capture logic: latches each channel's word and flag on its strobe
`timescale 1ns/10ps
module capture_model
  import adc_out_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Channel A
  input wire logic [WORD_W-1:0] word_a,
  input wire logic flag_a,
  input wire logic valid_a,
  // Channel B
  input wire logic [WORD_W-1:0] word_b,
  input wire logic flag_b,
  input wire logic valid_b,
  // Captured flag and word
  output logic [WORD_W:0] cap_a,
  output logic [WORD_W:0] cap_b
);
  always_ff @(posedge mclk) begin
    if (valid_a) begin
      cap_a <= {flag_a, word_a};
    end
  end

  always_ff @(posedge mclk) begin
    if (valid_b) begin
      cap_b <= {flag_b, word_b};
    end
  end
endmodule // capture_model

// [sim/dual_adc_parallel_output_tb.sv]
// Self-checking bench for the dual converter output block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module dual_adc_parallel_output_tb
  import adc_out_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [CODE_W-1:0] chan_a_stage_codes, chan_b_stage_codes;
  logic chan_a_over_range, chan_b_over_range, chan_a_oe_n, chan_a_oe_n_driven;
  logic chan_b_oe_n, chan_b_oe_n_driven, span_select;
  logic reference_source_select, reference_source_select_driven;
  logic [WORD_W-1:0] chan_a_word, chan_b_word;
  logic chan_a_word_oe, chan_b_word_oe, range_exceeded_flag_a, range_exceeded_flag_b;
  logic word_valid_strobe_a, word_valid_strobe_b, full_scale_3v, use_external_ref, irq;
  logic [WORD_W:0] cap_a, cap_b;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  dual_adc_parallel_output u_dual_adc_parallel_output (.*);

  capture_model u_capture_model (
    .mclk(mclk),
    .word_a(chan_a_word),
    .flag_a(range_exceeded_flag_a),
    .valid_a(word_valid_strobe_a),
    .word_b(chan_b_word),
    .flag_b(range_exceeded_flag_b),
    .valid_b(word_valid_strobe_b),
    .cap_a(cap_a),
    .cap_b(cap_b)
  );

  always #12.5 mclk = ~mclk;

  task final_report;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [1:0] er);
    logic pa, pw, ta, tw, got;
    logic [1:0] r;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      #1;
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge mclk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do begin
      #1;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
    end while (!got);
    s_axi_bready <= 1'b0;
    `CHK(r, er)
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ed,
                    input logic [1:0] er);
    logic pa, got;
    logic [1:0] r;
    logic [DATA_W-1:0] d;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      #1;
      pa = s_axi_arready;
      @(posedge mclk);
    end while (!pa);
    s_axi_arvalid <= 1'b0;
    do begin
      #1;
      got = s_axi_rvalid;
      r = s_axi_rresp;
      d = s_axi_rdata;
      @(posedge mclk);
    end while (!got);
    s_axi_rready <= 1'b0;
    `CHK(r, er)
    `CHK(d, ed)
  endtask

  // One sample on both channels, judged at the exact output cycle
  task automatic smp(input logic [CODE_W-1:0] ca, cb, input logic oa, ob, va, vb,
                     input logic [WORD_W-1:0] ea, eb);
    @(posedge mclk);
    chan_a_stage_codes <= ca;
    chan_b_stage_codes <= cb;
    chan_a_over_range <= oa;
    chan_b_over_range <= ob;
    @(posedge mclk);
    chan_a_stage_codes <= '0;
    chan_b_stage_codes <= '0;
    chan_a_over_range <= 1'b0;
    chan_b_over_range <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    `CHK(chan_a_word, 12'h000)
    @(posedge mclk);
    #1;
    `CHK(chan_a_word, ea)
    `CHK(chan_b_word, eb)
    `CHK(range_exceeded_flag_a, oa)
    `CHK(range_exceeded_flag_b, ob)
    `CHK(word_valid_strobe_a, va)
    `CHK(word_valid_strobe_b, vb)
    @(posedge mclk);
    #1;
    `CHK(cap_b, {ob, eb})
    if (va) `CHK(cap_a, {oa, ea})
  endtask

  task t_regs;
    rd(OFF_CTRL, 32'h3, RESP_OKAY);
    rd(OFF_IRQ_ENABLE, 32'h0, RESP_OKAY);
    rd(OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'h3, RESP_SLVERR);
    rd(OFF_IRQ_CLEAR, 32'h0, RESP_OKAY);
  endtask

  task t_irq;
    wr(OFF_IRQ_ENABLE, 32'h1, RESP_OKAY);
    smp(22'h000001, 22'h100000, 1'b1, 1'b0, 1'b1, 1'b1, 12'h400, 12'h001);
    `CHK(irq, 1'b1)
    rd(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
    wr(OFF_IRQ_CLEAR, 32'h1, RESP_OKAY);
    `CHK(irq, 1'b0)
    smp(22'h3aaaaa, 22'h0c0000, 1'b0, 1'b1, 1'b1, 1'b1, 12'hfff, 12'h004);
    `CHK(irq, 1'b0)
    rd(OFF_IRQ_STATUS, 32'h2, RESP_OKAY);
    wr(OFF_IRQ_ENABLE, 32'h3, RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(OFF_IRQ_CLEAR, 32'h2, RESP_OKAY);
    `CHK(irq, 1'b0)
  endtask

  task t_run;
    wr(OFF_CTRL, 32'h2, RESP_OKAY);
    rd(OFF_CTRL, 32'h2, RESP_OKAY);
    smp(22'h000002, 22'h000002, 1'b0, 1'b0, 1'b0, 1'b1, 12'h800, 12'h800);
    wr(OFF_CTRL, 32'h3, RESP_OKAY);
    // Byte lane 0 masked: run bits must not change
    @(posedge mclk);
    s_axi_wstrb <= 4'he;
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_CTRL, 32'h3, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    // Steady codes: captured words and pin status seen by software
    chan_a_stage_codes <= 22'h000001;
    chan_b_stage_codes <= 22'h0c0000;
    chan_b_over_range <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(OFF_WORD_A, 32'h400, RESP_OKAY);
    rd(OFF_WORD_B, 32'h1004, RESP_OKAY);
    rd(OFF_PINSTAT, 32'h3c, RESP_OKAY);
    `CHK(irq, 1'b1)
    chan_a_stage_codes <= '0;
    chan_b_stage_codes <= '0;
    chan_b_over_range <= 1'b0;
    repeat (8) @(posedge mclk);
    wr(OFF_IRQ_CLEAR, 32'h2, RESP_OKAY);
    rd(OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
    `CHK(irq, 1'b0)
  endtask

  task t_pins;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      chan_a_oe_n <= i[0];
      chan_a_oe_n_driven <= i[1];
      chan_b_oe_n <= !i[0];
      chan_b_oe_n_driven <= i[1];
      #1;
      `CHK(chan_a_word_oe, !(i[0] && i[1]))
      `CHK(chan_b_word_oe, !(!i[0] && i[1]))
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      span_select <= i[0];
      reference_source_select <= i[1];
      reference_source_select_driven <= i[2];
      @(posedge mclk);
      #1;
      `CHK(full_scale_3v, i[0])
      `CHK(use_external_ref, i[1] || !i[2])
    end
  endtask

  initial begin
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    chan_a_stage_codes = '0;
    chan_b_stage_codes = '0;
    chan_a_over_range = 1'b0;
    chan_b_over_range = 1'b0;
    chan_a_oe_n = 1'b0;
    chan_a_oe_n_driven = 1'b1;
    chan_b_oe_n = 1'b0;
    chan_b_oe_n_driven = 1'b1;
    span_select = 1'b0;
    reference_source_select = 1'b0;
    reference_source_select_driven = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_irq();
    t_run();
    t_pins();
    final_report();
  end
endmodule // dual_adc_parallel_output_tb
